/* rtl/ldir_pkg.sv */
// Package of constants and carriers for the logical device IRQ and DMA routing block.
package ldir_pkg;

   // ----------------------------------------------------------------------------
   // Configuration port locations
   // ----------------------------------------------------------------------------
   localparam logic [15:0] CFG_BASE_STRAP_LO = 16'h002E;
   localparam logic [15:0] CFG_BASE_STRAP_HI = 16'h004E;
   localparam logic [15:0] CFG_RELOC_MIN     = 16'h0100;
   localparam logic [15:0] CFG_RELOC_MAX     = 16'h0FFE;

   // ----------------------------------------------------------------------------
   // Configuration register indices
   // ----------------------------------------------------------------------------
   localparam logic [7:0] IDX_LDN       = 8'h07;
   localparam logic [7:0] IDX_PWR_CTRL  = 8'h22;
   localparam logic [7:0] IDX_OSC       = 8'h24;
   localparam logic [7:0] IDX_CFG_LO    = 8'h26;
   localparam logic [7:0] IDX_CFG_HI    = 8'h27;
   localparam logic [7:0] IDX_SMI_EN    = 8'h2B;
   localparam logic [7:0] IDX_ACTIVATE  = 8'h30;
   localparam logic [7:0] IDX_BASE_HI   = 8'h60;
   localparam logic [7:0] IDX_BASE_LO   = 8'h61;
   localparam logic [7:0] IDX_IRQ_SEL   = 8'h70;
   localparam logic [7:0] IDX_DMA_SEL   = 8'h74;

   // ----------------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------------
   localparam int OSC_FULL16_BIT = 6;

   // ----------------------------------------------------------------------------
   // Logical device numbers
   // ----------------------------------------------------------------------------
   localparam int          NUM_LDN     = 6;
   localparam logic [2:0]  LDN_FLOPPY  = 3'h0;
   localparam logic [2:0]  LDN_PARPORT = 3'h3;
   localparam logic [2:0]  LDN_UART1   = 3'h4;
   localparam logic [2:0]  LDN_UART2   = 3'h5;

   // ----------------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------------
   localparam logic [3:0] IRQ_SEL_RST_FLOPPY = 4'h6;
   localparam logic [3:0] IRQ_SEL_RST_OTHER  = 4'h0;
   localparam logic [2:0] DMA_SEL_RST_FLOPPY = 3'h2;
   localparam logic [2:0] DMA_SEL_RST_OTHER  = 3'h4;

   // ----------------------------------------------------------------------------
   // Base address windows and extended control modes
   // ----------------------------------------------------------------------------
   localparam logic [11:0] BASE_MIN         = 12'h100;
   localparam logic [11:0] BASE_MAX_8       = 12'hFF8;
   localparam logic [11:0] BASE_MAX_PARPORT = 12'hFFC;
   localparam logic [2:0]  ECR_MODE_FIFO    = 3'h2;
   localparam logic [2:0]  ECR_MODE_ECP     = 3'h3;
   localparam logic [2:0]  ECR_MODE_TEST    = 3'h6;

   // ----------------------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------------------
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } ldir_io_req_s;

   typedef struct packed {
      logic            floppy_dma_gate;
      logic            floppy_powered_down;
      logic            parport_irq_gate;
      logic            parport_ecp_en;
      logic [2:0]      ecp_mode;
      logic            ecp_service_irq_bit;
      logic            ecp_dma_gate;
      logic [1:0][3:0] uart_irq_enable_reg;
      logic [1:0]      uart_aux_out_irq_gate;
   } ldir_gate_s;

   typedef struct packed {
      logic       floppy_irq;
      logic       parport_irq;
      logic [1:0] uart_irq;
      logic       floppy_drq;
      logic       parport_drq;
   } ldir_fn_req_s;

endpackage

/* rtl/ldir_routing.sv */
// Configuration port, base decoding and IRQ/DMA routing of the logical devices.
module ldir_routing (
   input  wire logic                  clk_sys,
   input  wire logic                  reset,
   input  wire logic                  soft_reset,
   input  wire logic                  cfg_port_strap,
   input  wire ldir_pkg::ldir_io_req_s io_req,
   input  wire ldir_pkg::ldir_gate_s  fn_gate,
   input  wire ldir_pkg::ldir_fn_req_s fn_req,
   input  wire logic                  sys_mgmt_event,
   output logic [7:0]                 io_rdata_q,
   output logic                       io_rd_ack_q,
   output logic [5:0]                 dev_hit_q,
   output logic [15:0]                irq_q,
   output logic [15:0]                irq_oe_q,
   output logic [3:0]                 dma_req_q,
   output logic [3:0]                 dma_oe_q,
   output logic                       sys_mgmt_irq_n_q
);

   // ----------------------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------------------

   // Address compare on A11..A0, plus A15..A12 zero in full decode mode.
   function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] base,
                                     input logic [11:0] span_mask, input logic full16);
      addr_hit = ((addr[11:0] & ~span_mask) == (base[11:0] & ~span_mask))
                 && (!full16 || addr[15:12] == 4'h0);
   endfunction

   // Size of the decoded window of each logical device, as a mask of low bits.
   function automatic logic [11:0] dev_span(input int d);
      dev_span = (3'(d) == ldir_pkg::LDN_PARPORT) ? 12'h003 : 12'h007;
   endfunction

   // Only some device numbers are implemented.
   function automatic logic dev_impl(input int d);
      dev_impl = (3'(d) == ldir_pkg::LDN_FLOPPY) || (3'(d) == ldir_pkg::LDN_PARPORT)
                 || (3'(d) == ldir_pkg::LDN_UART1) || (3'(d) == ldir_pkg::LDN_UART2);
   endfunction

   // Base address lies in its allowed window and alignment.
   function automatic logic base_ok(input int d, input logic [15:0] base);
      logic [11:0] top;
      top = (3'(d) == ldir_pkg::LDN_PARPORT) ? ldir_pkg::BASE_MAX_PARPORT
                                             : ldir_pkg::BASE_MAX_8;
      base_ok = dev_impl(d) && base[15:12] == 4'h0 && base[11:0] >= ldir_pkg::BASE_MIN
                && base[11:0] <= top && (base[11:0] & dev_span(d)) == 12'h000;
   endfunction

   // ----------------------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------------------
   logic [7:0]  idx_q;
   logic [2:0]  ldn_q;
   logic [7:0]  osc_q;
   logic        smi_en_q;
   logic        strap_q;
   logic        cfg_reloc_q;
   logic [7:0]  cfg_lo_q;
   logic [15:0] cfg_base_q;
   logic [5:0]  act_q;
   logic [15:0] base_q    [ldir_pkg::NUM_LDN];
   logic [3:0]  irq_sel_q [ldir_pkg::NUM_LDN];
   logic [2:0]  dma_sel_q [ldir_pkg::NUM_LDN];

   logic [15:0] cfg_addr;
   logic        idx_hit;
   logic        data_hit;
   logic        full16;
   logic [15:0] cfg_new;
   logic        cur_impl;

   // Effective configuration port address and index/data decode.
   always_comb
   begin
      full16   = osc_q[ldir_pkg::OSC_FULL16_BIT];
      cfg_addr = cfg_reloc_q ? cfg_base_q
                 : (strap_q ? ldir_pkg::CFG_BASE_STRAP_HI : ldir_pkg::CFG_BASE_STRAP_LO);
      idx_hit  = addr_hit(io_req.addr, cfg_addr, 12'h000, full16);
      data_hit = addr_hit(io_req.addr, cfg_addr + 16'h0001, 12'h000, full16);
      cfg_new  = {io_req.wdata, cfg_lo_q};
      cur_impl = dev_impl(int'(ldn_q));
   end

   // Strap is sampled while reset is held and kept afterwards.
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         strap_q <= cfg_port_strap;
   end

   // Index register and global configuration registers.
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         idx_q       <= 8'h00;
         ldn_q       <= 3'h0;
         osc_q       <= 8'h00;
         smi_en_q    <= 1'b0;
         cfg_reloc_q <= 1'b0;
         cfg_lo_q    <= 8'h00;
         cfg_base_q  <= 16'h0000;
      end
      else if (io_req.wr && idx_hit)
         idx_q <= io_req.wdata;
      else if (io_req.wr && data_hit)
      begin
         if (idx_q == ldir_pkg::IDX_LDN)
            ldn_q <= io_req.wdata[2:0];
         else if (idx_q == ldir_pkg::IDX_OSC)
            osc_q <= io_req.wdata;
         else if (idx_q == ldir_pkg::IDX_SMI_EN)
            smi_en_q <= io_req.wdata[0];
         else if (idx_q == ldir_pkg::IDX_CFG_LO)
            cfg_lo_q <= io_req.wdata;
         else if (idx_q == ldir_pkg::IDX_CFG_HI && cfg_new[0] == 1'b0
                  && cfg_new >= ldir_pkg::CFG_RELOC_MIN && cfg_new <= ldir_pkg::CFG_RELOC_MAX)
         begin
            cfg_base_q  <= cfg_new;
            cfg_reloc_q <= 1'b1;
         end
      end
   end

   // Activate bit, shared with the power control bit of each device.
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         act_q <= 6'h00;
      else if (io_req.wr && data_hit && idx_q == ldir_pkg::IDX_PWR_CTRL)
      begin
         for (int d = 0; d < ldir_pkg::NUM_LDN; d++)
            act_q[d] <= io_req.wdata[d] && dev_impl(d);
      end
      else if (io_req.wr && data_hit && idx_q == ldir_pkg::IDX_ACTIVATE && cur_impl)
         act_q[ldn_q] <= io_req.wdata[0];
   end

   // Base address registers of each device.
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         for (int d = 0; d < ldir_pkg::NUM_LDN; d++)
            base_q[d] <= 16'h0000;
      end
      else if (io_req.wr && data_hit && cur_impl)
      begin
         if (idx_q == ldir_pkg::IDX_BASE_HI)
            base_q[ldn_q][15:8] <= io_req.wdata;
         else if (idx_q == ldir_pkg::IDX_BASE_LO)
            base_q[ldn_q][7:0] <= io_req.wdata;
      end
   end

   // Interrupt and DMA selects, restored on hard and on soft reset.
   always_ff @(posedge clk_sys)
   begin
      if (reset || soft_reset)
      begin
         for (int d = 0; d < ldir_pkg::NUM_LDN; d++)
         begin
            irq_sel_q[d] <= (3'(d) == ldir_pkg::LDN_FLOPPY) ? ldir_pkg::IRQ_SEL_RST_FLOPPY
                                                            : ldir_pkg::IRQ_SEL_RST_OTHER;
            dma_sel_q[d] <= (3'(d) == ldir_pkg::LDN_FLOPPY) ? ldir_pkg::DMA_SEL_RST_FLOPPY
                                                            : ldir_pkg::DMA_SEL_RST_OTHER;
         end
      end
      else if (io_req.wr && data_hit && cur_impl)
      begin
         if (idx_q == ldir_pkg::IDX_IRQ_SEL)
            irq_sel_q[ldn_q] <= io_req.wdata[3:0];
         else if (idx_q == ldir_pkg::IDX_DMA_SEL)
            dma_sel_q[ldn_q] <= io_req.wdata[2:0];
      end
   end

   // ----------------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------------
   logic [7:0] rdata_d;

   // Data port returns the indexed register; unimplemented indices read zero.
   always_comb
   begin
      rdata_d = 8'h00;
      if (idx_hit)
         rdata_d = idx_q;
      else if (idx_q == ldir_pkg::IDX_LDN)
         rdata_d = {5'h00, ldn_q};
      else if (idx_q == ldir_pkg::IDX_OSC)
         rdata_d = osc_q;
      else if (idx_q == ldir_pkg::IDX_SMI_EN)
         rdata_d = {7'h00, smi_en_q};
      else if (idx_q == ldir_pkg::IDX_CFG_LO)
         rdata_d = cfg_addr[7:0];
      else if (idx_q == ldir_pkg::IDX_CFG_HI)
         rdata_d = cfg_addr[15:8];
      else if (idx_q == ldir_pkg::IDX_PWR_CTRL)
         rdata_d = {2'h0, act_q};
      else if (!cur_impl)
         rdata_d = 8'h00;
      else if (idx_q == ldir_pkg::IDX_ACTIVATE)
         rdata_d = {7'h00, act_q[ldn_q]};
      else if (idx_q == ldir_pkg::IDX_BASE_HI)
         rdata_d = base_q[ldn_q][15:8];
      else if (idx_q == ldir_pkg::IDX_BASE_LO)
         rdata_d = base_q[ldn_q][7:0];
      else if (idx_q == ldir_pkg::IDX_IRQ_SEL)
         rdata_d = {4'h0, irq_sel_q[ldn_q]};
      else if (idx_q == ldir_pkg::IDX_DMA_SEL)
         rdata_d = {5'h00, dma_sel_q[ldn_q]};
   end

   // Read data and its acknowledge appear one cycle after the read strobe.
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         io_rdata_q  <= 8'h00;
         io_rd_ack_q <= 1'b0;
      end
      else
      begin
         io_rd_ack_q <= io_req.rd && (idx_hit || data_hit);
         io_rdata_q  <= (io_req.rd && (idx_hit || data_hit)) ? rdata_d : 8'h00;
      end
   end

   // ----------------------------------------------------------------------------
   // Function gating
   // ----------------------------------------------------------------------------
   logic [5:0] dev_ok;
   logic [5:0] dev_irq_en;
   logic [5:0] dev_dma_en;
   logic [5:0] dev_irq_req;
   logic [5:0] dev_drq;
   logic       fl_gate;
   logic       par_gate;
   logic       ecr_on_mode;

   // Each device's own enable condition, combined with activate and valid base.
   always_comb
   begin
      fl_gate     = fn_gate.floppy_dma_gate && !fn_gate.floppy_powered_down;
      ecr_on_mode = fn_gate.ecp_mode == ldir_pkg::ECR_MODE_FIFO
                    || fn_gate.ecp_mode == ldir_pkg::ECR_MODE_ECP
                    || fn_gate.ecp_mode == ldir_pkg::ECR_MODE_TEST;
      par_gate    = fn_gate.parport_ecp_en
                    ? ((ecr_on_mode || fn_gate.parport_irq_gate)
                       && !fn_gate.ecp_service_irq_bit)
                    : fn_gate.parport_irq_gate;
      for (int d = 0; d < ldir_pkg::NUM_LDN; d++)
         dev_ok[d] = act_q[d] && base_ok(d, base_q[d]);
      dev_irq_en  = 6'h00;
      dev_dma_en  = 6'h00;
      dev_irq_req = 6'h00;
      dev_drq     = 6'h00;
      dev_irq_en[ldir_pkg::LDN_FLOPPY]  = dev_ok[ldir_pkg::LDN_FLOPPY] && fl_gate;
      dev_dma_en[ldir_pkg::LDN_FLOPPY]  = dev_ok[ldir_pkg::LDN_FLOPPY] && fl_gate;
      dev_irq_en[ldir_pkg::LDN_PARPORT] = dev_ok[ldir_pkg::LDN_PARPORT] && par_gate;
      dev_dma_en[ldir_pkg::LDN_PARPORT] = dev_ok[ldir_pkg::LDN_PARPORT]
                                          && fn_gate.ecp_dma_gate;
      dev_irq_en[ldir_pkg::LDN_UART1]   = dev_ok[ldir_pkg::LDN_UART1]
                                          && |fn_gate.uart_irq_enable_reg[0]
                                          && fn_gate.uart_aux_out_irq_gate[0];
      dev_irq_en[ldir_pkg::LDN_UART2]   = dev_ok[ldir_pkg::LDN_UART2]
                                          && |fn_gate.uart_irq_enable_reg[1]
                                          && fn_gate.uart_aux_out_irq_gate[1];
      dev_irq_req[ldir_pkg::LDN_FLOPPY]  = fn_req.floppy_irq;
      dev_irq_req[ldir_pkg::LDN_PARPORT] = fn_req.parport_irq;
      dev_irq_req[ldir_pkg::LDN_UART1]   = fn_req.uart_irq[0];
      dev_irq_req[ldir_pkg::LDN_UART2]   = fn_req.uart_irq[1];
      dev_drq[ldir_pkg::LDN_FLOPPY]      = fn_req.floppy_drq;
      dev_drq[ldir_pkg::LDN_PARPORT]     = fn_req.parport_drq;
   end

   // ----------------------------------------------------------------------------
   // Routing matrix
   // ----------------------------------------------------------------------------
   logic [15:0] irq_d;
   logic [15:0] irq_oe_d;
   logic [3:0]  dma_d;
   logic [3:0]  dma_oe_d;
   logic [5:0]  hit_d;

   // Every line 1..15 is reachable; line 0 means no interrupt.
   always_comb
   begin
      irq_d    = 16'h0000;
      irq_oe_d = 16'h0000;
      dma_d    = 4'h0;
      dma_oe_d = 4'h0;
      hit_d    = 6'h00;
      for (int d = 0; d < ldir_pkg::NUM_LDN; d++)
      begin
         for (int n = 1; n < 16; n++)
         begin
            if (irq_sel_q[d] == 4'(n) && dev_irq_en[d])
            begin
               irq_oe_d[n] = 1'b1;
               irq_d[n]    = irq_d[n] | dev_irq_req[d];
            end
         end
         for (int c = 1; c < 4; c++)
         begin
            if (dma_sel_q[d] == 3'(c) && dev_dma_en[d])
            begin
               dma_oe_d[c] = 1'b1;
               dma_d[c]    = dma_d[c] | dev_drq[d];
            end
         end
         hit_d[d] = (io_req.wr || io_req.rd) && dev_ok[d]
                    && addr_hit(io_req.addr, base_q[d], dev_span(d), full16);
      end
   end

   // Registered line drivers and chip selects.
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         irq_q            <= 16'h0000;
         irq_oe_q         <= 16'h0000;
         dma_req_q        <= 4'h0;
         dma_oe_q         <= 4'h0;
         dev_hit_q        <= 6'h00;
         sys_mgmt_irq_n_q <= 1'b1;
      end
      else
      begin
         irq_q            <= irq_d;
         irq_oe_q         <= irq_oe_d;
         dma_req_q        <= dma_d;
         dma_oe_q         <= dma_oe_d;
         dev_hit_q        <= hit_d;
         sys_mgmt_irq_n_q <= !(smi_en_q && sys_mgmt_event);
      end
   end

   // ----------------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------------
   irq_line_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
      irq_oe_q[0] == 1'b0 && dma_oe_q[0] == 1'b0)
      else $error("Line zero was driven.");

   undriven_lines_a: assert property (@(posedge clk_sys) disable iff (reset)
      (irq_q & ~irq_oe_q) == 16'h0000 && (dma_req_q & ~dma_oe_q) == 4'h0)
      else $error("Request raised on an undriven line.");

   reset_defaults_a: assert property (@(posedge clk_sys) disable iff (reset)
      $past(reset) || $past(soft_reset) |-> irq_sel_q[0] == 4'h6 && dma_sel_q[0] == 3'h2
                       && dma_sel_q[3] == 3'h4 && irq_sel_q[3] == 4'h0)
      else $error("Select registers missed their reset values.");

   cfg_reloc_range_a: assert property (@(posedge clk_sys) disable iff (reset)
      cfg_reloc_q |-> cfg_addr[0] == 1'b0 && cfg_addr >= 16'h0100 && cfg_addr <= 16'h0FFE)
      else $error("Configuration port outside relocation window.");

   irq_sel_write_a: assert property (@(posedge clk_sys) disable iff (reset)
      io_req.wr && data_hit && idx_q == 8'h70 && cur_impl && !soft_reset
      |=> irq_sel_q[$past(ldn_q)] == $past(io_req.wdata[3:0]))
      else $error("Interrupt select write not stored.");

   floppy_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
      !fn_gate.floppy_dma_gate || fn_gate.floppy_powered_down
      |-> !dev_irq_en[0] && !dev_dma_en[0])
      else $error("Floppy routed with its gate closed.");

   uart_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
      !fn_gate.uart_aux_out_irq_gate[0] || fn_gate.uart_irq_enable_reg[0] == 4'h0
      |-> !dev_irq_en[4])
      else $error("Serial interrupt routed while disabled.");

   ecp_service_a: assert property (@(posedge clk_sys) disable iff (reset)
      fn_gate.parport_ecp_en && fn_gate.ecp_service_irq_bit |-> !dev_irq_en[3])
      else $error("Parallel interrupt passed with service bit set.");

   inactive_dev_a: assert property (@(posedge clk_sys) disable iff (reset)
      act_q == 6'h00 |=> irq_oe_q == 16'h0000 && dma_oe_q == 4'h0 && irq_q == 16'h0000)
      else $error("Inactive devices drove a line.");

endmodule

/* test/ldir_host.sv */
// Host chipset model that runs index and data cycles on the configuration port.
module ldir_host (
   input  wire logic                   clk_sys,
   input  wire logic                   io_rd_ack_q,
   input  wire logic [7:0]             io_rdata_q,
   output ldir_pkg::ldir_io_req_s      io_req
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] port = 16'h002E;
   initial io_req = '0;
   // One request held for one edge; released lines show inverted values.
   task automatic cyc(input logic w, input logic [15:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic ok);
      io_req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clk_sys);
      io_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
      ok = w;
      q = 8'h00;
      for (int i = 0; i < 3 && !ok; i++)
      begin
         #1;
         ok = io_rd_ack_q === 1'b1;
         q = io_rdata_q;
         if (!ok) @(posedge clk_sys);
      end
      @(posedge clk_sys);
   endtask
   // Index at the port, data at port plus one.
   task automatic put(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] q;
      logic       ok;
      cyc(1'b1, port, idx, q, ok);
      cyc(1'b1, port + 16'h0001, d, q, ok);
   endtask
   task automatic get(input logic [7:0] idx, output logic [7:0] q, output logic ok);
      cyc(1'b1, port, idx, q, ok);
      cyc(1'b0, port + 16'h0001, 8'h00, q, ok);
   endtask
endmodule

/* test/ldir_routing_test.sv */
// Self-checking bench of the logical device IRQ and DMA routing block.
module ldir_routing_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic                   clk_sys = 1'b0;
   logic                   reset = 1'b1;
   logic                   soft_reset = 1'b0;
   logic                   cfg_port_strap = 1'b0;
   logic                   sys_mgmt_event = 1'b0;
   ldir_pkg::ldir_gate_s   fn_gate = '0;
   ldir_pkg::ldir_fn_req_s fn_req = '0;
   ldir_pkg::ldir_io_req_s io_req;
   logic [7:0]             io_rdata_q;
   logic                   io_rd_ack_q;
   logic [15:0]            irq_q;
   logic [15:0]            irq_oe_q;
   logic [3:0]             dma_req_q;
   logic [3:0]             dma_oe_q;
   logic [5:0]             dev_hit_q;
   logic [7:0]             hq;
   logic                   hok;
   logic                   sys_mgmt_irq_n_q;
   logic [15:0]            lfsr = 16'hD764;
   int                     errors = 0;
   int                     n_checks = 0;
   logic                   en;
   logic                   pon;
   ldir_routing ldir_routing_inst (.clk_sys(clk_sys), .reset(reset), .soft_reset(soft_reset),
      .cfg_port_strap(cfg_port_strap), .io_req(io_req), .fn_gate(fn_gate), .fn_req(fn_req),
      .sys_mgmt_event(sys_mgmt_event), .io_rdata_q(io_rdata_q), .io_rd_ack_q(io_rd_ack_q),
      .dev_hit_q(dev_hit_q), .irq_q(irq_q), .irq_oe_q(irq_oe_q), .dma_req_q(dma_req_q),
      .dma_oe_q(dma_oe_q),
      .sys_mgmt_irq_n_q(sys_mgmt_irq_n_q));
   ldir_host ldir_host_inst (.clk_sys(clk_sys), .io_rd_ack_q(io_rd_ack_q),
      .io_rdata_q(io_rdata_q), .io_req(io_req));
   // Clock of 25 ns.
   always #12.5 clk_sys = ~clk_sys;
   // Compares one value and counts it.
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Reads a register; a missing answer ends the run.
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] q;
      logic       ok;
      ldir_host_inst.get(idx, q, ok);
      if (!ok)
      begin
         errors++;
         give_verdict();
      end
      check({8'h00, q}, {8'h00, exp});
   endtask
   // Expected line mask: a select inside 1..top-1 with its gate open drives that line.
   function automatic logic [15:0] sel_line(input int sel, input int top, input logic on);
      sel_line = (sel >= 1 && sel < top && on) ? 16'(1 << sel) : 16'h0000;
   endfunction
   // Next value of the stimulus shift register.
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      lfsr_next = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic settle();
      repeat (2) @(posedge clk_sys);
   endtask
   // Main sequence.
   initial
   begin
      repeat (20) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      check(irq_q, 16'h0000);
      check({15'h0, sys_mgmt_irq_n_q}, 16'h0001);
      ldir_host_inst.put(8'h07, 8'h03);
      rd(8'h70, 8'h00);
      rd(8'h74, 8'h04);
      ldir_host_inst.put(8'h07, 8'h00);
      rd(8'h70, 8'h06);
      rd(8'h74, 8'h02);
      ldir_host_inst.put(8'h30, 8'h01);
      ldir_host_inst.put(8'h60, 8'h03);
      ldir_host_inst.put(8'h61, 8'hF0);
      ldir_host_inst.put(8'h2B, 8'h00);
      fn_req <= '{floppy_irq: 1'b1, floppy_drq: 1'b1, default: 1'b0};
      for (int s = 0; s < 16; s++)
      begin
         lfsr = lfsr_next(lfsr);
         fn_gate.floppy_dma_gate <= lfsr[0];
         fn_gate.floppy_powered_down <= lfsr[1];
         ldir_host_inst.put(8'h70, 8'(s));
         ldir_host_inst.put(8'h74, 8'(s));
         settle();
         en = lfsr[0] && !lfsr[1];
         check(irq_q, sel_line(s, 16, en));
         check(irq_oe_q, sel_line(s, 16, en));
         check(16'(dma_req_q), sel_line(s % 8, 4, en));
         check(16'(dma_oe_q), sel_line(s % 8, 4, en));
      end
      fn_gate.floppy_dma_gate <= 1'b1;
      fn_gate.floppy_powered_down <= 1'b0;
      ldir_host_inst.put(8'h70, 8'h05);
      ldir_host_inst.put(8'h61, 8'hF4);
      settle();
      check(irq_q, 16'h0000);
      ldir_host_inst.put(8'h61, 8'hF0);
      ldir_host_inst.put(8'h22, 8'h00);
      settle();
      check(irq_q, 16'h0000);
      rd(8'h30, 8'h00);
      ldir_host_inst.put(8'h22, 8'h01);
      rd(8'h30, 8'h01);
      ldir_host_inst.put(8'h30, 8'h00);
      rd(8'h22, 8'h00);
      sys_mgmt_event <= 1'b1;
      ldir_host_inst.put(8'h2B, 8'h01);
      settle();
      check({15'h0, sys_mgmt_irq_n_q}, 16'h0000);
      soft_reset <= 1'b1;
      @(posedge clk_sys);
      soft_reset <= 1'b0;
      rd(8'h70, 8'h06);
      ldir_host_inst.put(8'h26, 8'h50);
      ldir_host_inst.put(8'h27, 8'h03);
      ldir_host_inst.port = 16'h1350;
      rd(8'h07, 8'h00);
      ldir_host_inst.put(8'h24, 8'h40);
      ldir_host_inst.put(8'h07, 8'h03);
      ldir_host_inst.port = 16'h0350;
      rd(8'h07, 8'h00);
      rd(8'h24, 8'h40);
      ldir_host_inst.put(8'h07, 8'h03);
      ldir_host_inst.put(8'h30, 8'h01);
      ldir_host_inst.put(8'h60, 8'h03);
      ldir_host_inst.put(8'h61, 8'h78);
      ldir_host_inst.put(8'h70, 8'h07);
      ldir_host_inst.put(8'h74, 8'h03);
      ldir_host_inst.cyc(1'b1, 16'h037A, 8'h00, hq, hok);
      check(16'(dev_hit_q), 16'h0008);
      ldir_host_inst.put(8'h61, 8'h7A);
      ldir_host_inst.cyc(1'b1, 16'h0378, 8'h00, hq, hok);
      check(16'(dev_hit_q), 16'h0000);
      ldir_host_inst.put(8'h61, 8'h78);
      ldir_host_inst.put(8'h07, 8'h04);
      ldir_host_inst.put(8'h30, 8'h01);
      ldir_host_inst.put(8'h60, 8'h03);
      ldir_host_inst.put(8'h61, 8'hF8);
      ldir_host_inst.put(8'h70, 8'h04);
      fn_req <= '{parport_irq: 1'b1, parport_drq: 1'b1, uart_irq: 2'h1, default: 1'b0};
      for (int s = 0; s < 12; s++)
      begin
         lfsr = lfsr_next(lfsr);
         fn_gate.parport_irq_gate         <= lfsr[0];
         fn_gate.parport_ecp_en           <= lfsr[1];
         fn_gate.ecp_mode                 <= lfsr[4:2];
         fn_gate.ecp_service_irq_bit      <= lfsr[5];
         fn_gate.ecp_dma_gate             <= lfsr[6];
         fn_gate.uart_irq_enable_reg[0]   <= lfsr[10:7] & {4{lfsr[11]}};
         fn_gate.uart_aux_out_irq_gate[0] <= lfsr[12];
         settle();
         en = lfsr[1] ? ((lfsr[4:2] inside {3'h2, 3'h3, 3'h6} || lfsr[0]) && !lfsr[5])
                      : lfsr[0];
         pon = (lfsr[10:7] & {4{lfsr[11]}}) != 4'h0 && lfsr[12];
         check(irq_q, sel_line(7, 16, en) | sel_line(4, 16, pon));
         check(irq_oe_q, sel_line(7, 16, en) | sel_line(4, 16, pon));
         check(16'(dma_req_q), sel_line(3, 4, lfsr[6]));
         check(16'(dma_oe_q), sel_line(3, 4, lfsr[6]));
      end
      cfg_port_strap <= 1'b1;
      reset <= 1'b1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      check(irq_q, 16'h0000);
      ldir_host_inst.port = 16'h004E;
      rd(8'h07, 8'h00);
      rd(8'h70, 8'h06);
      rd(8'h24, 8'h00);
      give_verdict();
   end
endmodule
